//--- hw/cdr_lock_detect_output_blank_input.sv
// lock detection, frequency acquisition, harmonic check and blanking
// assumes APB master on core_clk; pins are asynchronous to it
// What this block does
// - error over 1000 ppm raises loss-of-lock and starts acquisition
// - each acquisition first resets oscillator code to bottom, 10 MHz
// - steps up large then smaller; drops loss-of-lock within 250 ppm
// - on lock the frequency loop turns off, phase loop takes over
// - three modes: normal, reference-assisted, sticky indication
// - locked in normal mode, error over 0.1% restarts from bottom
// - loss-of-lock stays high until within 250 ppm: hysteresis
// - reference mode compares divided oscillator with divided reference
// - status bit 4 sets on any loss-of-lock and stays set
// - writing 1 then 0 to control B bit 6 clears the sticky bit
// - control B bit 7 selects sticky or live on the pin
// - lower-harmonic input forces loss-of-lock and reacquisition
// - higher harmonic is caught by the ordinary frequency error
// - harmonic decision spans 2^16 new-rate data transitions
// - harmonic detector is off in reference mode
// - split bit 0: blanking high zeros clock and data
// - split bit 1: high zeros data only, low zeros clock only
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cdr_lock_detect_output_blank_input #(
  parameter int WIN = cdr_pkg::WIN_TICKS,
  parameter int HARM = cdr_pkg::HARM_EDGES
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic serialDataIn,
  input wire logic dataBitTick,
  input wire logic oscTick,
  input wire logic referenceClockInput,
  input wire logic outputBlankInput,
  input wire logic recClkIn,
  input wire logic retimedDataIn,
  // oscillator control
  output logic [11:0] oscCode,
  output logic fllEnable,
  // link-side outputs
  output logic lockLostFlag,
  output logic recoveredClockOut,
  output logic recoveredDataOutPos,
  output logic recoveredDataOutNeg
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [6:0] pinRaw = {retimedDataIn, recClkIn, outputBlankInput, referenceClockInput,
                       oscTick, dataBitTick, serialDataIn};
  logic [6:0] syncA;
  logic [6:0] syncB;
  logic [3:0] syncC;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
        end else if (ce) begin
          syncA[gi] <= pinRaw[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (sys_rst) syncC <= 4'h0;
    else if (ce) syncC <= syncB[3:0];
  end
  wire dataEdge = syncB[0] ^ syncC[0];
  wire bitTickE = syncB[1] && !syncC[1];
  wire oscTickE = syncB[2] && !syncC[2];
  wire refTickE = syncB[3] && !syncC[3];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] controlWordA;
  logic [7:0] controlWordB;
  logic [7:0] controlWordC;
  logic sticky;
  logic liveLost;
  cdr_pkg::acq_e state;
  wire refEn = controlWordA[cdr_pkg::CA_REF_EN];
  wire apbAcc = psel && penable;
  wire apbDone = apbAcc && pready;
  wire apbWr = apbDone && pwrite;
  wire selA = paddr == cdr_pkg::ADDR_CTRL_A;
  wire selB = paddr == cdr_pkg::ADDR_CTRL_B;
  wire selC = paddr == cdr_pkg::ADDR_CTRL_C;
  wire selS = paddr == cdr_pkg::ADDR_STATUS;
  wire mapped = selA || selB || selC || selS;
  // a 1-then-0 sequence on the clear bit releases the sticky flag
  wire stickyClr = apbWr && selB && controlWordB[cdr_pkg::CB_STICKY_CLR]
                   && !pwdata[cdr_pkg::CB_STICKY_CLR];
  // a 0-to-1 on the reference enable starts a fresh lock-to-reference
  wire refRestart = apbWr && selA && !refEn && pwdata[cdr_pkg::CA_REF_EN];
  wire [31:0] statusWord = {4'h0, oscCode, 11'h000, sticky, 2'b00, fllEnable, liveLost};
  wire [31:0] readMux = selA ? {24'h000000, controlWordA} :
                        selB ? {24'h000000, controlWordB} :
                        selC ? {24'h000000, controlWordC} :
                        selS ? statusWord : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      controlWordA <= cdr_pkg::CTRL_A_RST;
      controlWordB <= cdr_pkg::CTRL_B_RST;
      controlWordC <= cdr_pkg::CTRL_C_RST;
    end else if (ce) begin
      // one wait state: pready follows the first access cycle
      pready <= apbAcc && !pready;
      pslverr <= apbAcc && !pready && !mapped;
      prdata <= (apbAcc && !pready && !pwrite) ? readMux : 32'h00000000;
      if (apbWr && selA) controlWordA <= pwdata[7:0];
      if (apbWr && selB) controlWordB <= pwdata[7:0];
      if (apbWr && selC) controlWordC <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // frequency meter
  // ------------------------------------------------------------
  meas_if mi ();
  logic go;
  assign mi.go = go;
  assign mi.divOsc = refEn ? controlWordA[cdr_pkg::CA_RATIO_LO +: 4] : 4'h0;
  assign mi.divTgt = refEn ? controlWordA[cdr_pkg::CA_RANGE_LO +: 2] : 2'b00;
  freq_meter #(.WIN(WIN)) u_meter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .oscTick(oscTickE),
    .tgtTick(refEn ? refTickE : bitTickE),
    .m(mi.meter)
  );
  localparam logic [19:0] WIN20 = 20'(WIN);
  wire oscLow = mi.oscCount < WIN20;
  wire [19:0] absErr = oscLow ? WIN20 - mi.oscCount : mi.oscCount - WIN20;
  wire inLock = absErr <= cdr_pkg::THR_LOCK;
  wire overLoss = absErr > cdr_pkg::THR_LOSS;

  // ------------------------------------------------------------
  // harmonic detector
  // ------------------------------------------------------------
  logic [1:0] runLen;
  logic shortSeen;
  logic [16:0] edgeCnt;
  wire harmArm = (state == cdr_pkg::ST_LOCKED) && !refEn;
  wire harmEnd = harmArm && dataEdge && (edgeCnt == 17'(HARM - 1));
  // no single-bit run in the whole span means the data slowed by a harmonic
  wire harmHit = harmEnd && !shortSeen && !(runLen == 2'd1);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      runLen <= 2'd0;
      shortSeen <= 1'b0;
      edgeCnt <= 17'h00000;
    end else if (ce) begin
      if (!harmArm || harmEnd) begin
        runLen <= 2'd0;
        shortSeen <= 1'b0;
        edgeCnt <= 17'h00000;
      end else if (dataEdge) begin
        runLen <= 2'd0;
        if (runLen == 2'd1) shortSeen <= 1'b1;
        edgeCnt <= edgeCnt + 17'h00001;
      end else if (oscTickE && runLen != 2'd3) begin
        runLen <= runLen + 2'd1;
      end
    end
  end

  // ------------------------------------------------------------
  // acquisition state machine
  // ------------------------------------------------------------
  logic [11:0] step;
  cdr_pkg::acq_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      cdr_pkg::ST_BOTTOM: next_state = cdr_pkg::ST_ADJUST;
      cdr_pkg::ST_ADJUST: if (mi.done && inLock) next_state = cdr_pkg::ST_LOCKED;
      cdr_pkg::ST_LOCKED: if ((mi.done && overLoss) || harmHit) begin
        next_state = cdr_pkg::ST_BOTTOM;
      end
      default: next_state = cdr_pkg::ST_BOTTOM;
    endcase
    if (refRestart) next_state = cdr_pkg::ST_BOTTOM;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= cdr_pkg::ST_BOTTOM;
      oscCode <= cdr_pkg::CODE_BOTTOM;
      step <= cdr_pkg::STEP_FIRST;
      go <= 1'b0;
      liveLost <= 1'b1;
      fllEnable <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      liveLost <= next_state != cdr_pkg::ST_LOCKED;
      fllEnable <= next_state != cdr_pkg::ST_LOCKED;
      go <= (next_state != cdr_pkg::ST_BOTTOM) && (state == cdr_pkg::ST_BOTTOM || mi.done);
      if (next_state == cdr_pkg::ST_BOTTOM) begin
        oscCode <= cdr_pkg::CODE_BOTTOM;
        step <= cdr_pkg::STEP_FIRST;
      end else if (state == cdr_pkg::ST_ADJUST && mi.done && !inLock) begin
        if (oscLow) begin
          // large steps first; saturate at the top of the range
          oscCode <= (oscCode > 12'hFFF - step) ? 12'hFFF : oscCode + step;
        end else begin
          // overshoot: back off and refine the step
          oscCode <= (oscCode < step) ? cdr_pkg::CODE_BOTTOM : oscCode - step;
          if (step != 12'h001) step <= step >> 1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // sticky flag and pin
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sticky <= 1'b0;
      lockLostFlag <= 1'b1;
    end else if (ce) begin
      sticky <= liveLost || (sticky && !stickyClr);
      lockLostFlag <= controlWordB[cdr_pkg::CB_STATIC_PIN] ? sticky : liveLost;
    end
  end

  output_blanker u_blank (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .blank(syncB[4]),
    .splitMode(controlWordC[cdr_pkg::CC_SPLIT_BLANK]),
    .clkIn(syncB[5]),
    .dataIn(syncB[6]),
    .recovered_clock_out(recoveredClockOut),
    .dataPos(recoveredDataOutPos),
    .dataNeg(recoveredDataOutNeg)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || !ce);
  sequence s_lockHit;
    state == cdr_pkg::ST_ADJUST && mi.done && inLock && !refRestart;
  endsequence
  sequence s_lockShown;
    state == cdr_pkg::ST_LOCKED && !liveLost && !fllEnable;
  endsequence
  property p_lockDeassert;
    s_lockHit |=> s_lockShown;
  endproperty
  a_lockDeassert: assert property (p_lockDeassert) else $error("lock not declared");
  property p_lossRestart;
    state == cdr_pkg::ST_LOCKED && mi.done && overLoss |=> liveLost
      ##1 (oscCode == cdr_pkg::CODE_BOTTOM && state == cdr_pkg::ST_ADJUST);
  endproperty
  a_lossRestart: assert property (p_lossRestart) else $error("no restart on loss");
  property p_bottom;
    state == cdr_pkg::ST_BOTTOM |-> ##1 oscCode == cdr_pkg::CODE_BOTTOM;
  endproperty
  a_bottom: assert property (p_bottom) else $error("code not at bottom");
  property p_fllOff;
    state == cdr_pkg::ST_LOCKED |-> !fllEnable && !liveLost;
  endproperty
  a_fllOff: assert property (p_fllOff) else $error("frequency loop on while locked");
  property p_stickySet;
    liveLost |=> sticky;
  endproperty
  a_stickySet: assert property (p_stickySet) else $error("sticky missed");
  property p_stickyClr;
    stickyClr && !liveLost |=> !sticky;
  endproperty
  a_stickyClr: assert property (p_stickyClr) else $error("sticky not cleared");
  property p_pinSticky;
    controlWordB[cdr_pkg::CB_STATIC_PIN] |=> lockLostFlag == $past(sticky);
  endproperty
  a_pinSticky: assert property (p_pinSticky) else $error("pin not mirroring");
  property p_harmOff;
    refEn |-> !harmHit;
  endproperty
  a_harmOff: assert property (p_harmOff) else $error("harmonic check active");
  property p_harmRestart;
    harmHit && !refRestart |=> state == cdr_pkg::ST_BOTTOM ##1 lockLostFlag || sticky;
  endproperty
  a_harmRestart: assert property (p_harmRestart) else $error("harmonic ignored");
endmodule : cdr_lock_detect_output_blank_input
`default_nettype wire

//--- hw/cdr_pkg.sv
// constants shared by the lock-detect, meter and blanking logic
// assumes a 100 MHz core clock and an APB master with 32-bit data
package cdr_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_C_RST = 8'h00;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CA_REF_EN = 0;
  localparam int CA_RATIO_LO = 2;
  localparam int CA_RANGE_LO = 6;
  localparam int CB_STICKY_CLR = 6;
  localparam int CB_STATIC_PIN = 7;
  localparam int CC_SPLIT_BLANK = 1;
  localparam int ST_LIVE = 0;
  localparam int ST_FLL = 1;
  localparam int ST_STICKY = 4;
  localparam int ST_CODE_LO = 16;
  // ------------------------------------------------------------
  // frequency comparison
  // ------------------------------------------------------------
  localparam int LOCK_PPM = 250;
  localparam int LOSS_PPM = 1000;
  localparam int WIN_TICKS = 65536;
  localparam int HARM_EDGES = 65536;
  localparam logic [19:0] THR_LOCK = 20'(LOCK_PPM * WIN_TICKS / 1000000);
  localparam logic [19:0] THR_LOSS = 20'(LOSS_PPM * WIN_TICKS / 1000000);
  localparam logic [11:0] CODE_BOTTOM = 12'h000;
  localparam logic [11:0] STEP_FIRST = 12'h400;
  typedef enum logic [1:0] {
    ST_BOTTOM = 2'b00,
    ST_ADJUST = 2'b01,
    ST_LOCKED = 2'b10
  } acq_e;
endpackage : cdr_pkg

//--- hw/freq_meter.sv
// counts divided oscillator ticks over a window of divided target ticks
// assumes tick inputs are one-cycle pulses already in the core_clk domain
`timescale 1ns/10ps
`default_nettype none
module freq_meter #(
  parameter int WIN = cdr_pkg::WIN_TICKS
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // ticks
  input wire logic oscTick,
  input wire logic tgtTick,
  // control side
  meas_if.meter m
);
  logic [7:0] oscPre;
  logic [3:0] tgtPre;
  logic [16:0] tgtCnt;
  logic running;
  wire [7:0] oscMask = 8'((16'h0001 << m.divOsc) - 16'h0001);
  wire [3:0] tgtMask = 4'((8'h01 << m.divTgt) - 8'h01);
  wire oscDiv = oscTick && ((oscPre & oscMask) == oscMask);
  wire tgtDiv = tgtTick && ((tgtPre & tgtMask) == tgtMask);
  wire lastTick = running && tgtDiv && (tgtCnt == 17'(WIN - 1));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oscPre <= 8'h00;
      tgtPre <= 4'h0;
      tgtCnt <= 17'h00000;
      running <= 1'b0;
      m.done <= 1'b0;
      m.oscCount <= 20'h00000;
    end else if (ce) begin
      m.done <= lastTick;
      if (oscTick) oscPre <= oscPre + 8'h01;
      if (tgtTick) tgtPre <= tgtPre + 4'h1;
      if (m.go) begin
        running <= 1'b1;
        tgtCnt <= 17'h00000;
        m.oscCount <= 20'h00000;
      end else if (running) begin
        if (oscDiv && m.oscCount != 20'hFFFFF) m.oscCount <= m.oscCount + 20'h00001;
        if (tgtDiv) tgtCnt <= tgtCnt + 17'h00001;
        if (lastTick) running <= 1'b0;
      end
    end
  end
endmodule : freq_meter
`default_nettype wire

//--- hw/meas_if.sv
// request and result of one frequency-measurement window
// assumes both ends run on core_clk
`timescale 1ns/10ps
`default_nettype none
interface meas_if;
  logic go;
  logic [3:0] divOsc;
  logic [1:0] divTgt;
  logic done;
  logic [19:0] oscCount;
  modport meter (input go, input divOsc, input divTgt, output done, output oscCount);
  modport ctrl (output go, output divOsc, output divTgt, input done, input oscCount);
endinterface : meas_if
`default_nettype wire

//--- hw/output_blanker.sv
// forces recovered clock and/or data to zero under the blanking input
// assumes synchronised level inputs
`timescale 1ns/10ps
`default_nettype none
module output_blanker (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // control
  input wire logic blank,
  input wire logic splitMode,
  // recovered signals
  input wire logic clkIn,
  input wire logic dataIn,
  output logic recovered_clock_out,
  output logic dataPos,
  output logic dataNeg
);
  wire killBoth = !splitMode && blank;
  wire killData = killBoth || (splitMode && blank);
  wire killClk = killBoth || (splitMode && !blank);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      recovered_clock_out <= 1'b0;
      dataPos <= 1'b0;
      dataNeg <= 1'b0;
    end else if (ce) begin
      recovered_clock_out <= killClk ? 1'b0 : clkIn;
      dataPos <= killData ? 1'b0 : dataIn;
      dataNeg <= killData ? 1'b0 : !dataIn;
    end
  end
endmodule : output_blanker
`default_nettype wire

//--- verif/line_partner.sv
// far-side model: serial data, oscillator and reference strobes
// assumes rates come from the bench as phase steps per core_clk
`timescale 1ns/10ps
`default_nettype none
module line_partner (
  // clock
  input wire logic core_clk,
  // rate settings
  input wire logic [11:0] oscCode,
  input wire logic [15:0] dataInc,
  input wire logic [15:0] refInc,
  input wire logic lowHarmonic,
  // strobes and data towards the block
  output logic oscTick,
  output logic dataBitTick,
  output logic referenceClockInput,
  output logic serialDataIn
);
  // ------------------------------------------------------------
  // phase accumulators
  // ------------------------------------------------------------
  logic [15:0] oscAcc = 16'h0000;
  logic [15:0] dataAcc = 16'h0000;
  logic [15:0] refAcc = 16'h1234;
  logic oscPrev = 1'b0;
  logic skip = 1'b0;
  logic [15:0] oscInc;
  // oscillator rises linearly with its code; code 0 is the slowest
  assign oscInc = 16'({oscCode, 2'b00}) + 16'h0400;
  assign oscTick = oscAcc[15];
  assign dataBitTick = dataAcc[15];
  assign referenceClockInput = refAcc[15];
  initial serialDataIn = 1'b0;
  always @(posedge core_clk) begin
    oscAcc <= oscAcc + oscInc;
    dataAcc <= dataAcc + dataInc;
    refAcc <= refAcc + refInc;
    oscPrev <= oscAcc[15];
    // a lower harmonic holds every bit for two oscillator periods
    if (oscAcc[15] && !oscPrev) begin
      skip <= !skip;
      if (!lowHarmonic || skip) begin
        serialDataIn <= !serialDataIn;
      end
    end
  end
endmodule : line_partner
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench: acquisition, hysteresis, sticky flag, harmonic, blanking
// assumes cdr_pkg, the design and line_partner are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------
  localparam int LIMIT = 99000;
  localparam logic [7:0] RA = cdr_pkg::ADDR_CTRL_A;
  localparam logic [7:0] RB = cdr_pkg::ADDR_CTRL_B;
  localparam logic [7:0] RC = cdr_pkg::ADDR_CTRL_C;
  localparam logic [7:0] RS = cdr_pkg::ADDR_STATUS;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic dataBitTick, oscTick, referenceClockInput, serialDataIn;
  logic outputBlankInput = 1'b0;
  logic recClkIn = 1'b0;
  logic retimedDataIn = 1'b0;
  logic [11:0] oscCode;
  logic fllEnable, lockLostFlag;
  logic recoveredClockOut, recoveredDataOutPos, recoveredDataOutNeg;
  logic [15:0] dataInc = 16'h2000;
  logic [15:0] refInc = 16'h2000;
  logic lowHarmonic = 1'b0;
  int nMismatch = 0;
  int nChecks = 0;
  int cycles = 0;
  int waited = 0;
  always #5 core_clk = ~core_clk;
  // short window keeps each measurement window to a few thousand cycles
  cdr_lock_detect_output_blank_input #(.WIN(256), .HARM(64)) u_dut (
    .core_clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serialDataIn, .dataBitTick, .oscTick, .referenceClockInput,
    .outputBlankInput, .recClkIn, .retimedDataIn, .oscCode, .fllEnable, .lockLostFlag,
    .recoveredClockOut, .recoveredDataOutPos, .recoveredDataOutNeg
  );
  line_partner u_far (.core_clk, .oscCode, .dataInc, .refInc, .lowHarmonic, .oscTick,
    .dataBitTick, .referenceClockInput, .serialDataIn);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  function automatic logic [31:0] b1(input logic x);
    return {31'h0, x};
  endfunction : b1
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h2, "bus answer not after one wait state");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask,
      input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd & mask, exp, msg);
  endtask : rchk
  task automatic wait_flag(input logic v, input int lim, input string msg);
    waited = 0;
    while (lockLostFlag !== v && waited < lim) begin
      @(posedge core_clk);
      waited++;
    end
    chk(b1(lockLostFlag), b1(v), msg);
  endtask : wait_flag
  task automatic hold_lock(input int cyc, input string msg);
    int n;
    n = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      n += int'(lockLostFlag !== 1'b0);
    end
    chk(32'(n), 32'h0, msg);
  endtask : hold_lock
  // lock band of +-16 counts in 256, widened by four counts each side
  task automatic chk_code(input logic [15:0] inc, input string msg);
    logic [31:0] o;
    o = ({20'h0, oscCode} << 2) + 32'h400;
    nChecks++;
    if ($isunknown(o) || o * 256 < inc * 236 || o * 256 > inc * 276) begin
      nMismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk_code
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk({19'h0, fllEnable, oscCode}, 32'h1000, "loop or code after reset");
    chk(b1(lockLostFlag), 32'h1, "flag after reset");
    rchk(RA, 32'h0, 32'hFFFF_FFFF, "control a reset");
    rchk(RB, 32'h0, 32'hFFFF_FFFF, "control b reset");
    rchk(RC, 32'h0, 32'hFFFF_FFFF, "control c reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
  endtask : t_reset
  task automatic t_acquire;
    wait_flag(1'b0, 40000, "no lock");
    chk(b1(fllEnable), 32'h0, "frequency loop on after lock");
    chk_code(dataInc, "code outside lock band");
    rchk(RS, {4'h0, oscCode, 16'h0010}, 32'h0FFF_0013, "status after lock");
  endtask : t_acquire
  task automatic t_sticky;
    dataInc <= 16'h2300;
    hold_lock(6000, "lock dropped inside hysteresis");
    dataInc <= 16'h2000;
    apb(1'b1, RB, 32'h80);
    repeat (6) @(posedge core_clk);
    chk(b1(lockLostFlag), 32'h1, "pin ignores sticky");
    apb(1'b1, RB, 32'hC0);
    apb(1'b1, RB, 32'h80);
    rchk(RS, 32'h0, 32'h10, "sticky not cleared");
    repeat (6) @(posedge core_clk);
    chk(b1(lockLostFlag), 32'h0, "pin set after clear");
    apb(1'b1, RB, 32'h0);
  endtask : t_sticky
  task automatic t_step;
    dataInc <= 16'h3000;
    wait_flag(1'b1, 8000, "no loss after rate step");
    repeat (4) if (oscCode !== 12'h000) @(posedge core_clk);
    chk({19'h0, fllEnable, oscCode}, 32'h1000, "no restart from bottom");
    wait_flag(1'b0, 40000, "no relock");
    chk_code(16'h3000, "code outside new band");
    rchk(RS, 32'h10, 32'h10, "sticky missed the loss");
  endtask : t_step
  task automatic t_harm;
    lowHarmonic <= 1'b1;
    wait_flag(1'b1, 6000, "harmonic not caught");
    chk(b1(waited >= 600), 32'h1, "harmonic decision too early");
    lowHarmonic <= 1'b0;
    refInc <= 16'h1800;
    apb(1'b1, RA, 32'h05);
    wait_flag(1'b0, 40000, "no lock to reference");
    chk_code(16'h3000, "code off reference target");
    lowHarmonic <= 1'b1;
    hold_lock(3000, "harmonic check live in reference mode");
    lowHarmonic <= 1'b0;
    refInc <= 16'h1000;
    wait_flag(1'b1, 12000, "no loss against reference");
    apb(1'b1, RA, 32'h0);
  endtask : t_harm
  task automatic t_blank;
    logic sp, bl, d;
    logic [2:0] got;
    for (int i = 0; i < 8; i++) begin
      {sp, bl, d} = 3'(i);
      apb(1'b1, RC, {30'h0, sp, 1'b0});
      outputBlankInput <= bl;
      retimedDataIn <= d;
      recClkIn <= !d;
      repeat (6) @(posedge core_clk);
      got = {recoveredClockOut, recoveredDataOutPos, recoveredDataOutNeg};
      chk({29'h0, got}, {29'h0, !d & !(bl ^ sp), d & !bl, !d & !bl}, "blanking");
    end
  endtask : t_blank
  // enable low must hold acquisition mid-flight: code and pin stay put
  task automatic t_freeze;
    logic [11:0] c;
    logic f;
    ce <= 1'b0;
    @(posedge core_clk);
    c = oscCode;
    f = lockLostFlag;
    repeat (3000) @(posedge core_clk);
    chk({19'h0, lockLostFlag, oscCode}, {19'h0, f, c}, "state moved with enable low");
    ce <= 1'b1;
    @(posedge core_clk);
  endtask : t_freeze
  // ------------------------------------------------------------
  // sequence and timeout
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nMismatch++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_acquire;
    t_sticky;
    t_step;
    t_harm;
    t_freeze;
    t_blank;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
